// *** core/ims_sequencer.sv ***
// Inherent-mode bus cycle sequencer with operand address forming
`timescale 1ns/100ps
`include "ims_defines.svh"

module ims_sequencer #(
  parameter int unsigned ADDR_W = 16
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Instruction start and core state
  input wire logic start_in,
  input wire logic [ADDR_W-1:0] pc_in,
  input wire logic [ADDR_W-1:0] sp_in,
  input wire logic [7:0] acc_a_in,
  input wire logic [7:0] acc_b_in,
  input wire logic [7:0] ccr_in,
  input wire logic [15:0] index_x_in,
  input wire logic [15:0] index_y_in,
  input wire logic test_mode_in,
  input wire logic irq_in,
  input wire logic [ADDR_W-1:0] vec_in,
  // Memory bus
  input wire logic [7:0] rdata_in,
  output logic bus_valid_out,
  output logic [ADDR_W-1:0] bus_addr_out,
  output logic bus_rw_out,
  output logic [7:0] bus_wdata_out,
  // Sequencer status
  output logic busy_out,
  output logic waiting_out,
  output logic done_out,
  output logic pull_valid_out,
  output logic [15:0] pull_data_out,
  // Operand forming
  input wire logic opnd_req_in,
  input wire ims_pkg::ims_opnd_t opnd_mode_in,
  input wire logic [7:0] opnd_b1_in,
  input wire logic [7:0] opnd_b2_in,
  input wire logic [15:0] opnd_base_in,
  output logic [15:0] opnd_addr_out,
  // Bit manipulation
  input wire logic [7:0] bit_target_in,
  input wire logic [7:0] bit_mask_in,
  input wire logic bit_set_in,
  output logic [7:0] bit_result_out,
  output logic bit_hit_out
);

  // Address arithmetic below is fixed at sixteen bits
  if (ADDR_W != 16) begin : g_addr_w_check
    $error("ims_sequencer serves a 16-bit address bus only");
  end

  ims_pkg::ims_state_t state_r, state_nxt;
  ims_pkg::ims_cls_t cls_r, cls_nxt;
  logic page_r, page_nxt;
  logic acc_b_r, acc_b_nxt;
  logic [3:0] step_r, step_nxt;
  logic [15:0] opa_r, opa_nxt;
  logic valid_r, valid_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic rw_r, rw_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic done_r, done_nxt;
  logic pvalid_r, pvalid_nxt;
  logic [15:0] pdata_r, pdata_nxt;
  logic [15:0] opnd_r, opnd_nxt;
  logic [7:0] bres_r, bres_nxt;
  logic bhit_r, bhit_nxt;

  function automatic ims_pkg::ims_cls_t decode(input logic [7:0] op, input logic pg, input logic tm);
    if (pg) begin
      unique case (op)
        `IMS_OP_SP_TO_IX: return ims_pkg::CLS_SP_Y4;
        `IMS_OP_PSH_X: return ims_pkg::CLS_PUSH_Y;
        default: return ims_pkg::CLS_Y4;
      endcase
    end
    unique case (op)
      // Outside test modes the test opcode behaves as a plain two-cycle op
      `IMS_OP_TEST: return tm ? ims_pkg::CLS_TEST : ims_pkg::CLS_REG2;
      `IMS_OP_WAIT: return ims_pkg::CLS_WAIT;
      `IMS_OP_PSH_A, `IMS_OP_PSH_B: return ims_pkg::CLS_PUSH_ACC;
      `IMS_OP_PUL_A, `IMS_OP_PUL_B: return ims_pkg::CLS_PULL_ACC;
      `IMS_OP_PSH_X: return ims_pkg::CLS_PUSH_X;
      `IMS_OP_PUL_X: return ims_pkg::CLS_PULL_X;
      `IMS_OP_SP_TO_IX, `IMS_OP_SP_DEC, `IMS_OP_SP_INC: return ims_pkg::CLS_SP3;
      `IMS_OP_ADD_B_IX, `IMS_OP_SHL_D, `IMS_OP_SHR_D, `IMS_OP_DEC_IX, `IMS_OP_INC_IX,
      `IMS_OP_IX_TO_SP, `IMS_OP_XCHG_D: return ims_pkg::CLS_DUMMY3;
      default: return ims_pkg::CLS_REG2;
    endcase
  endfunction

  function automatic logic [3:0] cls_len(input ims_pkg::ims_cls_t c);
    unique case (c)
      ims_pkg::CLS_REG2, ims_pkg::CLS_TEST: return `IMS_LEN_REG;
      ims_pkg::CLS_DUMMY3, ims_pkg::CLS_SP3, ims_pkg::CLS_PUSH_ACC: return `IMS_LEN_THREE;
      ims_pkg::CLS_Y4, ims_pkg::CLS_SP_Y4, ims_pkg::CLS_PUSH_X, ims_pkg::CLS_PULL_ACC: return `IMS_LEN_FOUR;
      ims_pkg::CLS_PUSH_Y, ims_pkg::CLS_PULL_X: return `IMS_LEN_FIVE;
      ims_pkg::CLS_WAIT: return `IMS_LEN_WAIT;
      // Codes past the last class cannot be decoded
      default: return `IMS_LEN_REG;
    endcase
  endfunction

  // Stacked byte for wait-instruction cycle k, pushed from SP downward
  function automatic logic [7:0] wait_byte(input logic [3:0] k, input logic [15:0] ret);
    unique case (k)
      4'd3: return ret[7:0];
      4'd4: return ret[15:8];
      4'd5: return index_y_in[7:0];
      4'd6: return index_y_in[15:8];
      4'd7: return index_x_in[7:0];
      4'd8: return index_x_in[15:8];
      4'd9: return acc_a_in;
      4'd10: return acc_b_in;
      default: return ccr_in;
    endcase
  endfunction

  logic [3:0] k;
  assign k = step_r + 4'd1;

  always_comb begin
    state_nxt = state_r;
    cls_nxt = cls_r;
    page_nxt = page_r;
    acc_b_nxt = acc_b_r;
    step_nxt = step_r;
    opa_nxt = opa_r;
    valid_nxt = 1'b0;
    addr_nxt = addr_r;
    rw_nxt = 1'b1;
    wdata_nxt = wdata_r;
    done_nxt = 1'b0;
    pvalid_nxt = 1'b0;
    pdata_nxt = pdata_r;
    unique case (state_r)
      ims_pkg::ST_IDLE: begin
        if (start_in) begin
          state_nxt = ims_pkg::ST_RUN;
          page_nxt = 1'b0;
          step_nxt = 4'd1;
          opa_nxt = pc_in;
          valid_nxt = 1'b1;
          addr_nxt = pc_in;
        end
      end
      ims_pkg::ST_RUN: begin
        valid_nxt = 1'b1;
        step_nxt = k;
        // Pulled bytes arrive high first, then low
        if (cls_r == ims_pkg::CLS_PULL_ACC && step_r == 4'd4) begin
          pdata_nxt = {8'h00, rdata_in};
        end
        if (cls_r == ims_pkg::CLS_PULL_X && step_r == 4'd4) begin
          pdata_nxt[15:8] = rdata_in;
        end
        if (cls_r == ims_pkg::CLS_PULL_X && step_r == 4'd5) begin
          pdata_nxt[7:0] = rdata_in;
        end
        if (step_r == 4'd1) begin
          page_nxt = (rdata_in == `IMS_OP_PAGE);
          cls_nxt = decode(rdata_in, 1'b0, test_mode_in);
          acc_b_nxt = rdata_in[0];
          addr_nxt = opa_r + 16'h0001;
          if (rdata_in != `IMS_OP_PAGE && decode(rdata_in, 1'b0, test_mode_in) == ims_pkg::CLS_TEST) begin
            state_nxt = ims_pkg::ST_TEST;
          end
        end else if (step_r == 4'd2 && page_r) begin
          cls_nxt = decode(rdata_in, 1'b1, 1'b0);
          addr_nxt = opa_r + 16'h0002;
        end else if (step_r == cls_len(cls_r)) begin
          state_nxt = ims_pkg::ST_IDLE;
          valid_nxt = 1'b0;
          done_nxt = 1'b1;
          pvalid_nxt = (cls_r == ims_pkg::CLS_PULL_ACC) || (cls_r == ims_pkg::CLS_PULL_X);
        end else if (cls_r == ims_pkg::CLS_WAIT && step_r == `IMS_WAIT_STACK_END) begin
          state_nxt = ims_pkg::ST_WAIT;
          addr_nxt = `IMS_ALL_ONES;
        end else begin
          unique case (cls_r)
            ims_pkg::CLS_DUMMY3, ims_pkg::CLS_Y4: addr_nxt = `IMS_ALL_ONES;
            ims_pkg::CLS_SP3, ims_pkg::CLS_SP_Y4: addr_nxt = sp_in;
            ims_pkg::CLS_PUSH_ACC: begin
              addr_nxt = sp_in;
              rw_nxt = 1'b0;
              wdata_nxt = acc_b_r ? acc_b_in : acc_a_in;
            end
            ims_pkg::CLS_PUSH_X, ims_pkg::CLS_PUSH_Y: begin
              // Low byte first at SP, then high byte below it
              rw_nxt = 1'b0;
              if (k == cls_len(cls_r)) begin
                addr_nxt = sp_in - 16'h0001;
                wdata_nxt = (cls_r == ims_pkg::CLS_PUSH_X) ? index_x_in[15:8] : index_y_in[15:8];
              end else begin
                addr_nxt = sp_in;
                wdata_nxt = (cls_r == ims_pkg::CLS_PUSH_X) ? index_x_in[7:0] : index_y_in[7:0];
              end
            end
            ims_pkg::CLS_PULL_ACC, ims_pkg::CLS_PULL_X: addr_nxt = sp_in + {12'h000, k - 4'd3};
            ims_pkg::CLS_WAIT: begin
              if (k == `IMS_LEN_WAIT) begin
                addr_nxt = addr_r + 16'h0001;
              end else if (k == `IMS_WAIT_STACK_END) begin
                addr_nxt = `IMS_ALL_ONES;
              end else begin
                addr_nxt = sp_in - {12'h000, k - 4'd3};
                rw_nxt = 1'b0;
                wdata_nxt = wait_byte(k, opa_r + 16'h0001);
              end
            end
            default: addr_nxt = `IMS_ALL_ONES;
          endcase
        end
      end
      ims_pkg::ST_WAIT: begin
        valid_nxt = 1'b1;
        addr_nxt = `IMS_ALL_ONES;
        if (irq_in) begin
          state_nxt = ims_pkg::ST_RUN;
          step_nxt = `IMS_WAIT_VEC1;
          addr_nxt = vec_in;
        end
      end
      ims_pkg::ST_TEST: begin
        // Only reset leaves this state
        valid_nxt = 1'b1;
        addr_nxt = addr_r + 16'h0001;
      end
    endcase
  end

  always_comb begin
    unique case (opnd_mode_in)
      ims_pkg::OPND_DIRECT: opnd_nxt = ims_pkg::ims_direct(opnd_b1_in);
      ims_pkg::OPND_INDEXED: opnd_nxt = ims_pkg::ims_indexed(opnd_base_in, opnd_b1_in);
      ims_pkg::OPND_RELATIVE: opnd_nxt = ims_pkg::ims_relative(opnd_base_in, opnd_b1_in);
      ims_pkg::OPND_WIDE: opnd_nxt = ims_pkg::ims_join16(opnd_b1_in, opnd_b2_in);
    endcase
    if (!opnd_req_in) begin
      opnd_nxt = opnd_r;
    end
    bres_nxt = bit_set_in ? (bit_target_in | bit_mask_in) : (bit_target_in & ~bit_mask_in);
    bhit_nxt = |(bit_target_in & bit_mask_in);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= ims_pkg::ST_IDLE;
      cls_r <= ims_pkg::CLS_REG2;
      page_r <= 1'b0;
      acc_b_r <= 1'b0;
      step_r <= 4'd0;
      opa_r <= 16'h0000;
      valid_r <= 1'b0;
      addr_r <= 16'h0000;
      rw_r <= 1'b1;
      wdata_r <= 8'h00;
      done_r <= 1'b0;
      pvalid_r <= 1'b0;
      pdata_r <= 16'h0000;
      opnd_r <= 16'h0000;
      bres_r <= 8'h00;
      bhit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cls_r <= cls_nxt;
      page_r <= page_nxt;
      acc_b_r <= acc_b_nxt;
      step_r <= step_nxt;
      opa_r <= opa_nxt;
      valid_r <= valid_nxt;
      addr_r <= addr_nxt;
      rw_r <= rw_nxt;
      wdata_r <= wdata_nxt;
      done_r <= done_nxt;
      pvalid_r <= pvalid_nxt;
      pdata_r <= pdata_nxt;
      opnd_r <= opnd_nxt;
      bres_r <= bres_nxt;
      bhit_r <= bhit_nxt;
    end
  end

  assign bus_valid_out = valid_r;
  assign bus_addr_out = addr_r;
  assign bus_rw_out = rw_r;
  assign bus_wdata_out = wdata_r;
  assign busy_out = (state_r != ims_pkg::ST_IDLE);
  assign waiting_out = (state_r == ims_pkg::ST_WAIT);
  assign done_out = done_r;
  assign pull_valid_out = pvalid_r;
  assign pull_data_out = pdata_r;
  assign opnd_addr_out = opnd_r;
  assign bit_result_out = bres_r;
  assign bit_hit_out = bhit_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  AST_DIRECT_PAGE0: assert property (
    opnd_req_in && opnd_mode_in == ims_pkg::OPND_DIRECT |=> opnd_addr_out == {8'h00, $past(opnd_b1_in)})
    else $error("direct operand not in page zero");

  AST_INDEXED_UNSIGNED: assert property (
    opnd_req_in && opnd_mode_in == ims_pkg::OPND_INDEXED
    |=> opnd_addr_out == $past(opnd_base_in) + {8'h00, $past(opnd_b1_in)})
    else $error("indexed offset not added unsigned");

  AST_RELATIVE_SIGNED: assert property (
    opnd_req_in && opnd_mode_in == ims_pkg::OPND_RELATIVE && opnd_b1_in[7]
    |=> opnd_addr_out < $past(opnd_base_in) || $past(opnd_base_in) < 16'h0080)
    else $error("negative displacement did not go backward");

  AST_WIDE_ORDER: assert property (
    opnd_req_in && opnd_mode_in == ims_pkg::OPND_WIDE
    |=> opnd_addr_out[15:8] == $past(opnd_b1_in) && opnd_addr_out[7:0] == $past(opnd_b2_in))
    else $error("wide operand byte order wrong");

  AST_MASK_KEEP: assert property (
    1'b1 |=> (bit_result_out & ~$past(bit_mask_in)) == ($past(bit_target_in) & ~$past(bit_mask_in)))
    else $error("unmasked bit changed");

  AST_TEST_COUNTS: assert property (
    state_r == ims_pkg::ST_TEST |=> state_r == ims_pkg::ST_TEST && bus_addr_out == $past(bus_addr_out) + 16'h0001)
    else $error("test instruction stopped counting");

  AST_WAIT_ENTRY: assert property (
    state_r == ims_pkg::ST_RUN && cls_r == ims_pkg::CLS_WAIT && step_r == `IMS_WAIT_STACK_END && !done_out
    |=> waiting_out && bus_addr_out == 16'hffff && bus_rw_out)
    else $error("wait state not entered after twelve cycles");

  AST_VECTOR_FETCH: assert property (
    waiting_out && irq_in |=> bus_addr_out == $past(vec_in) ##1 bus_addr_out == $past(vec_in, 2) + 16'h0001
    ##1 done_out && !busy_out)
    else $error("vector fetch not two cycles");

  AST_REG2_SEQ: assert property (
    state_r == ims_pkg::ST_IDLE && start_in ##1 rdata_in == 8'h01
    |=> bus_addr_out == $past(pc_in, 2) + 16'h0001 && bus_rw_out ##1 done_out)
    else $error("two-cycle op sequence wrong");

  AST_PUSH_X_HIGH: assert property (
    state_r == ims_pkg::ST_RUN && cls_r == ims_pkg::CLS_PUSH_X && step_r == 4'd3
    |-> !bus_rw_out && bus_addr_out == $past(sp_in) ##1 !bus_rw_out && bus_addr_out == $past(sp_in) - 16'h0001)
    else $error("push X byte placement wrong");

  AST_RW_STORE_ONLY: assert property (
    bus_valid_out && !bus_rw_out |-> cls_r inside {ims_pkg::CLS_PUSH_ACC, ims_pkg::CLS_PUSH_X,
    ims_pkg::CLS_PUSH_Y, ims_pkg::CLS_WAIT} && step_r >= 4'd3)
    else $error("write strobe outside a store cycle");

endmodule

// *** core/ims_defines.svh ***
// Constants for the inherent-mode bus cycle sequencer
// What this block does
// - Direct operand is low byte, high byte zero
// - Indexed offset unsigned 0..255, added to index
// - Branch offset signed, relative to following byte
// - Sixteen-bit operands take high then low byte
// - Mask ones select bits modified or tested
// - Test instruction counts address forever until reset
// - Wait instruction: 12 cycles, then n wait
// - Two vector fetch cycles, 14 plus n total
// - Register-only ops: opcode, then discard opcode+1
// - Three-cycle ops end at all-ones or SP
// - Paged Y ops: four cycles ending all-ones
// - Stack-to-Y: four cycles ending at SP
// - Accumulator push writes at SP, cycle three
// - Push X: low at SP, high SP-1
// - Push Y: five cycles, low SP, high SP-1
// - Pull accumulator reads operand from SP+1
// - Pull X: high SP+1, low SP+2
`ifndef IMS_DEFINES_SVH
`define IMS_DEFINES_SVH

`define IMS_ALL_ONES 16'hffff
`define IMS_OP_PAGE 8'h18
`define IMS_OP_TEST 8'h00
`define IMS_OP_WAIT 8'h3e
`define IMS_OP_PSH_A 8'h36
`define IMS_OP_PSH_B 8'h37
`define IMS_OP_PUL_A 8'h32
`define IMS_OP_PUL_B 8'h33
`define IMS_OP_PSH_X 8'h3c
`define IMS_OP_PUL_X 8'h38
`define IMS_OP_SP_TO_IX 8'h30
`define IMS_OP_SP_DEC 8'h34
`define IMS_OP_SP_INC 8'h31
`define IMS_OP_ADD_B_IX 8'h3a
`define IMS_OP_SHL_D 8'h05
`define IMS_OP_SHR_D 8'h04
`define IMS_OP_DEC_IX 8'h09
`define IMS_OP_INC_IX 8'h08
`define IMS_OP_IX_TO_SP 8'h35
`define IMS_OP_XCHG_D 8'h8f

`define IMS_LEN_REG 4'd2
`define IMS_LEN_THREE 4'd3
`define IMS_LEN_FOUR 4'd4
`define IMS_LEN_FIVE 4'd5
`define IMS_LEN_WAIT 4'd14
`define IMS_WAIT_STACK_END 4'd12
`define IMS_WAIT_VEC1 4'd13

`endif

// *** core/ims_pkg.sv ***
// Types and operand arithmetic for the inherent-mode bus cycle sequencer
package ims_pkg;

  typedef enum logic [3:0] {
    CLS_REG2, CLS_DUMMY3, CLS_SP3, CLS_Y4, CLS_SP_Y4, CLS_PUSH_ACC, CLS_PUSH_X,
    CLS_PUSH_Y, CLS_PULL_ACC, CLS_PULL_X, CLS_WAIT, CLS_TEST
  } ims_cls_t;

  typedef enum logic [1:0] {
    OPND_DIRECT, OPND_INDEXED, OPND_RELATIVE, OPND_WIDE
  } ims_opnd_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_RUN, ST_WAIT, ST_TEST
  } ims_state_t;

  function automatic logic [15:0] ims_direct(input logic [7:0] b);
    return {8'h00, b};
  endfunction

  function automatic logic [15:0] ims_indexed(input logic [15:0] ix, input logic [7:0] off);
    return ix + {8'h00, off};
  endfunction

  function automatic logic [15:0] ims_relative(input logic [15:0] nxt, input logic [7:0] off);
    return nxt + {{8{off[7]}}, off};
  endfunction

  function automatic logic [15:0] ims_join16(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

endpackage

// *** test/ims_mem_model.sv ***
// Memory and peripheral model on the far side of the sequencer bus
`timescale 1ns/100ps
module ims_mem_model (
  // Clock
  input wire logic clk_in,
  // Bus from the sequencer
  input wire logic bus_valid_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic bus_rw_in,
  input wire logic [7:0] bus_wdata_in,
  // Read data, same cycle as address
  output logic [7:0] rdata_out
);
  logic [7:0] mem_r [0:65535];
  logic [7:0] last_r;

  initial begin
    last_r = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem_r[i] = i[7:0] ^ 8'h5a;
    end
  end

  task automatic poke(input logic [15:0] a, input logic [7:0] d);
    mem_r[a] = d;
  endtask

  // Outside read cycles show the inverse of the last byte, never a stale copy
  always @* begin
    if (bus_valid_in && bus_rw_in) begin
      rdata_out = mem_r[bus_addr_in];
    end else begin
      rdata_out = ~last_r;
    end
  end

  always @(posedge clk_in) begin
    if (bus_valid_in) begin
      last_r <= bus_rw_in ? rdata_out : bus_wdata_in;
      if (!bus_rw_in) begin
        mem_r[bus_addr_in] <= bus_wdata_in;
      end
    end
  end
endmodule

// *** test/tb_inherent_mode_bus_cycle_sequencer.sv ***
// Self-checking bench for the inherent-mode bus cycle sequencer
`timescale 1ns/100ps
`include "ims_defines.svh"
module tb_inherent_mode_bus_cycle_sequencer;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in = 1'b0;
  logic irq_in = 1'b0;
  logic test_mode_in = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [15:0] sp = 16'h01f0;
  logic [15:0] vec = 16'hfff2;
  logic [15:0] index_x = 16'h4a5b;
  logic [15:0] index_y = 16'h6c7d;
  logic [7:0] acc_a = 8'hc1;
  logic [7:0] acc_b = 8'hd2;
  logic [7:0] ccr = 8'he3;
  logic opnd_req = 1'b0;
  ims_pkg::ims_opnd_t opnd_mode = ims_pkg::OPND_DIRECT;
  logic [7:0] opnd_b1 = 8'h00;
  logic [7:0] opnd_b2 = 8'h00;
  logic [15:0] opnd_base = 16'h0000;
  logic [7:0] bit_tgt = 8'h00;
  logic [7:0] bit_mask = 8'h00;
  logic bit_set = 1'b0;
  logic [7:0] rdata, bus_wdata_out, bit_result_out;
  logic [15:0] bus_addr_out, pull_data_out, opnd_addr_out;
  logic bus_valid_out, bus_rw_out, busy_out, waiting_out, done_out, pull_valid_out, bit_hit_out;
  logic [15:0] got_a[$], exp_a[$];
  logic got_rw[$], exp_rw[$];
  logic [7:0] got_d[$], exp_d[$];
  int err_total = 0;
  int total_checks = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;

  ims_sequencer dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .start_in(start_in), .pc_in(pc_in), .sp_in(sp),
    .acc_a_in(acc_a), .acc_b_in(acc_b), .ccr_in(ccr), .index_x_in(index_x), .index_y_in(index_y),
    .test_mode_in(test_mode_in), .irq_in(irq_in), .vec_in(vec), .rdata_in(rdata), .bus_valid_out(bus_valid_out),
    .bus_addr_out(bus_addr_out), .bus_rw_out(bus_rw_out), .bus_wdata_out(bus_wdata_out), .busy_out(busy_out),
    .waiting_out(waiting_out), .done_out(done_out), .pull_valid_out(pull_valid_out), .pull_data_out(pull_data_out),
    .opnd_req_in(opnd_req), .opnd_mode_in(opnd_mode), .opnd_b1_in(opnd_b1), .opnd_b2_in(opnd_b2),
    .opnd_base_in(opnd_base), .opnd_addr_out(opnd_addr_out), .bit_target_in(bit_tgt), .bit_mask_in(bit_mask),
    .bit_set_in(bit_set), .bit_result_out(bit_result_out), .bit_hit_out(bit_hit_out));

  ims_mem_model mem (.clk_in(sys_clk_in), .bus_valid_in(bus_valid_out), .bus_addr_in(bus_addr_out),
    .bus_rw_in(bus_rw_out), .bus_wdata_in(bus_wdata_out), .rdata_out(rdata));

  // Bus monitor: one entry per bus cycle
  always @(posedge sys_clk_in) begin
    if (bus_valid_out === 1'b1) begin
      got_a.push_back(bus_addr_out);
      got_rw.push_back(bus_rw_out);
      got_d.push_back(bus_wdata_out);
    end
  end

  task automatic chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic ex(input logic [15:0] a, input logic rw, input logic [7:0] d);
    exp_a.push_back(a);
    exp_rw.push_back(rw);
    exp_d.push_back(d);
  endtask

  task automatic prep(input logic [15:0] pc, input logic [7:0] b0, input logic [7:0] b1);
    exp_a.delete();
    exp_rw.delete();
    exp_d.delete();
    mem.poke(pc, b0);
    mem.poke(pc + 16'h0001, b1);
    ex(pc, 1'b1, 8'h00);
    ex(pc + 16'h0001, 1'b1, 8'h00);
  endtask

  // Called at a clock edge with the sequencer idle
  task automatic run_op(input string nm, input logic [15:0] pc, input bit wt, output logic [15:0] pd,
                        output logic pv);
    int k;
    int n;
    got_a.delete();
    got_rw.delete();
    got_d.delete();
    start_in <= 1'b1;
    pc_in <= pc;
    @(posedge sys_clk_in);
    start_in <= 1'b0;
    k = 0;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      k++;
      if (waiting_out === 1'b1) n++;
      if (n == 4) irq_in <= 1'b1;
    end while (done_out !== 1'b1 && k < 80);
    pv = pull_valid_out;
    pd = pull_data_out;
    irq_in <= 1'b0;
    chk({nm, " done"}, 20'(k < 80), 20'h1);
    if (wt) begin
      chk("wait_len", 20'(n >= 4 && n <= 6), 20'h1);
      for (int i = 0; i < n; i++) begin
        exp_a.insert(12, 16'hffff);
        exp_rw.insert(12, 1'b1);
        exp_d.insert(12, 8'h00);
      end
      ex(vec, 1'b1, 8'h00);
      ex(vec + 16'h0001, 1'b1, 8'h00);
    end
    chk({nm, " cycles"}, 20'(got_a.size()), 20'(exp_a.size()));
    for (int i = 0; i < got_a.size() && i < exp_a.size(); i++) begin
      chk({nm, " addr"}, 20'(got_a[i]), 20'(exp_a[i]));
      chk({nm, " rw"}, 20'(got_rw[i]), 20'(exp_rw[i]));
      if (exp_rw[i] === 1'b0) chk({nm, " data"}, 20'(got_d[i]), 20'(exp_d[i]));
    end
  endtask

  task automatic t_inh();
    logic [7:0] op [13] = '{8'h4f, 8'h01, `IMS_OP_TEST, `IMS_OP_ADD_B_IX, `IMS_OP_SHL_D, `IMS_OP_SHR_D,
      `IMS_OP_DEC_IX, `IMS_OP_INC_IX, `IMS_OP_IX_TO_SP, `IMS_OP_XCHG_D, `IMS_OP_SP_TO_IX, `IMS_OP_SP_DEC,
      `IMS_OP_SP_INC};
    logic [15:0] pd;
    logic pv;
    for (int i = 0; i < 13; i++) begin
      prep(16'h2000 + 16'(i * 4), op[i], 8'h01);
      if (i >= 10) ex(sp, 1'b1, 8'h00);
      else if (i >= 3) ex(16'hffff, 1'b1, 8'h00);
      run_op("inherent", 16'h2000 + 16'(i * 4), 1'b0, pd, pv);
    end
  endtask

  task automatic t_page();
    logic [7:0] op [6] = '{`IMS_OP_XCHG_D, `IMS_OP_DEC_IX, `IMS_OP_INC_IX, `IMS_OP_ADD_B_IX, `IMS_OP_IX_TO_SP,
      `IMS_OP_SP_TO_IX};
    logic [15:0] pd;
    logic pv;
    for (int i = 0; i < 6; i++) begin
      prep(16'h3000, `IMS_OP_PAGE, op[i]);
      ex(16'h3002, 1'b1, 8'h00);
      ex(i == 5 ? sp : 16'hffff, 1'b1, 8'h00);
      run_op("paged", 16'h3000, 1'b0, pd, pv);
    end
  endtask

  task automatic t_stack();
    logic [15:0] pd;
    logic pv;
    for (int i = 0; i < 2; i++) begin
      prep(16'h4000, i ? `IMS_OP_PSH_B : `IMS_OP_PSH_A, 8'h01);
      ex(sp, 1'b0, i ? acc_b : acc_a);
      run_op("push_acc", 16'h4000, 1'b0, pd, pv);
      mem.poke(sp + 16'h0001, 8'h9e - 8'(i));
      prep(16'h4010, i ? `IMS_OP_PUL_B : `IMS_OP_PUL_A, 8'h01);
      ex(sp, 1'b1, 8'h00);
      ex(sp + 16'h0001, 1'b1, 8'h00);
      run_op("pull_acc", 16'h4010, 1'b0, pd, pv);
      chk("pull_acc", {pv, pd}, {1'b1, 8'h00, 8'h9e - 8'(i)});
    end
    prep(16'h4020, `IMS_OP_PSH_X, 8'h01);
    ex(sp, 1'b0, index_x[7:0]);
    ex(sp - 16'h0001, 1'b0, index_x[15:8]);
    run_op("push_x", 16'h4020, 1'b0, pd, pv);
    prep(16'h4030, `IMS_OP_PAGE, `IMS_OP_PSH_X);
    ex(16'h4032, 1'b1, 8'h00);
    ex(sp, 1'b0, index_y[7:0]);
    ex(sp - 16'h0001, 1'b0, index_y[15:8]);
    run_op("push_y", 16'h4030, 1'b0, pd, pv);
    mem.poke(sp + 16'h0001, 8'hb4);
    mem.poke(sp + 16'h0002, 8'hc5);
    prep(16'h4040, `IMS_OP_PUL_X, 8'h01);
    for (int i = 0; i < 3; i++) ex(sp + 16'(i), 1'b1, 8'h00);
    run_op("pull_x", 16'h4040, 1'b0, pd, pv);
    chk("pull_x", {pv, pd}, {1'b1, 16'hb4c5});
  endtask

  task automatic t_wait();
    logic [15:0] pd;
    logic pv;
    logic [7:0] st [9];
    st = '{8'h01, 8'h50, index_y[7:0], index_y[15:8], index_x[7:0], index_x[15:8], acc_a, acc_b, ccr};
    prep(16'h5000, `IMS_OP_WAIT, 8'h01);
    for (int i = 0; i < 9; i++) ex(sp - 16'(i), 1'b0, st[i]);
    ex(16'hffff, 1'b1, 8'h00);
    run_op("wait", 16'h5000, 1'b1, pd, pv);
  endtask

  // Counting must run on with no end, so only a reset stops it
  task automatic t_test();
    got_a.delete();
    mem.poke(16'h6000, `IMS_OP_TEST);
    test_mode_in <= 1'b1;
    start_in <= 1'b1;
    pc_in <= 16'h6000;
    @(posedge sys_clk_in);
    start_in <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk_in);
      if (done_out !== 1'b0) chk("test done", 20'(done_out), 20'h0);
    end
    chk("test count", 20'(got_a.size() >= 38), 20'h1);
    for (int i = 0; i < got_a.size(); i++) chk("test addr", 20'(got_a[i]), 20'(16'h6000 + 16'(i)));
    rst_in <= 1'b1;
    test_mode_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    chk("test stop", {bus_valid_out, busy_out}, 20'h0);
  endtask

  // Back-to-back requests; each answer is sampled two edges after it was driven
  task automatic t_opnd_bit();
    ims_pkg::ims_opnd_t md [6] = '{ims_pkg::OPND_DIRECT, ims_pkg::OPND_INDEXED, ims_pkg::OPND_INDEXED,
      ims_pkg::OPND_RELATIVE, ims_pkg::OPND_RELATIVE, ims_pkg::OPND_WIDE};
    logic [7:0] b1 [6] = '{8'hc3, 8'hff, 8'h00, 8'h80, 8'h7f, 8'hab};
    logic [15:0] base [6] = '{16'hffff, 16'h1234, 16'h1234, 16'h1000, 16'h1000, 16'h0000};
    logic [15:0] res [6] = '{16'h00c3, 16'h1333, 16'h1234, 16'h0f80, 16'h107f, 16'hab54};
    // Bit cases pack set, target and mask; results pack result and hit
    logic [16:0] bt [6] = '{17'h0a50f, 17'h1a50f, 17'h1a55a, 17'h0a55a, 17'h100ff, 17'h0ff80};
    logic [8:0] bres [6] = '{9'h141, 9'h15f, 9'h1fe, 9'h14a, 9'h1fe, 9'h0ff};
    for (int i = 0; i < 7; i++) begin
      opnd_req <= (i < 6);
      if (i < 6) begin
        opnd_mode <= md[i];
        opnd_b1 <= b1[i];
        opnd_base <= base[i];
        opnd_b2 <= ~b1[i];
        {bit_set, bit_tgt, bit_mask} <= bt[i];
      end
      @(posedge sys_clk_in);
      if (i > 0) chk("opnd", 20'(opnd_addr_out), 20'(res[i - 1]));
      if (i > 0) chk("bit", 20'({bit_result_out, bit_hit_out}), 20'(bres[i - 1]));
    end
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk_in);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_inh();
    t_page();
    t_stack();
    t_wait();
    t_test();
    t_opnd_bit();
    wrap_up();
  end
endmodule
